// ---- pvg_regs.sv ----
// input turn-off threshold and paged current-sense gain command registers
//
// Behaviour
// - turn-off threshold exponent is fixed at 11110 (-2), 0.25 V step
// - writes into read-only exponent bits are dropped, fixed contents kept
// - turn-off mantissa accepted from 16 to 63, 4 V to 15.75 V
// - turn-off threshold powers up at 6 V unless a stored value overrides
// - gain is sense voltage over current in ohms, winding resistance senses
// - gain spans 0.244 to 7.751 milliohm in 15.26 microohm steps
// - page 00 selects channel 1, 01 channel 2, 11 both channels
// - page 0 gain writes always taken, page 1 only when channel 2 is master
// - slave channel 2 uses the page 0 gain value
// - page 1 gain write to a slave is nacked, flags invalid command, alerts
// - gain powers up at 0.5035 milliohm unless a stored value overrides
// - gain exponent is fixed at 10000 (-16), 15.26 microohm step
// - gain mantissa accepted from 16 to 508
// - out-of-range threshold write flags invalid data and alerts, value kept
`timescale 1ns/1ps
module pvg_regs #(
	parameter logic [pvg_pkg::MANT_W-1:0] P_OFF_MANT_POWERUP = pvg_pkg::OFF_MANT_DEF,
	parameter logic [pvg_pkg::MANT_W-1:0] P_GAIN_MANT_POWERUP = pvg_pkg::GAIN_MANT_DEF
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [pvg_pkg::CMD_W-1:0] i_cmd,
	input wire logic [pvg_pkg::PAGE_W-1:0] i_page,
	input wire logic [pvg_pkg::WORD_W-1:0] i_wdata,
	input wire logic i_ch2_slave,
	input wire logic i_clear_faults,
	output logic o_ack,
	output logic o_nack,
	output logic [pvg_pkg::WORD_W-1:0] o_rdata,
	output logic [pvg_pkg::WORD_W-1:0] o_input_turn_off_threshold,
	output logic [pvg_pkg::WORD_W-1:0] o_gain_ch1,
	output logic [pvg_pkg::WORD_W-1:0] o_gain_ch2,
	output logic o_cml_fault,
	output logic o_invalid_data,
	output logic o_invalid_command_fault,
	output logic o_smbalert_out,
	output logic o_smbalert_oe
);
	import pvg_pkg::*;

	// linear word: signed exponent above signed mantissa
	function automatic logic [WORD_W-1:0] lin_word(input logic [EXP_W-1:0] e,
			input logic [MANT_W-1:0] m);
		lin_word = {e, m};
	endfunction : lin_word

	function automatic logic in_range(input logic [MANT_W-1:0] m,
			input logic [MANT_W-1:0] lo, input logic [MANT_W-1:0] hi);
		// signed compare so negative mantissas fall out of range
		in_range = ($signed(m) >= $signed(lo)) && ($signed(m) <= $signed(hi));
	endfunction : in_range

	logic [MANT_W-1:0] off_mant;
	logic [MANT_W-1:0] gain1_mant;
	logic [MANT_W-1:0] gain2_mant;
	logic [MANT_W-1:0] wr_mant;

	// only the mantissa is taken; exponent bits of the write are dropped
	assign wr_mant = i_wdata[MANT_W-1:0];

	wire is_off = i_cmd == CMD_INPUT_TURN_OFF;
	wire is_gain = i_cmd == CMD_CURRENT_SENSE_GAIN;
	wire known = is_off | is_gain;
	wire pg_ch1 = i_page == PAGE_CH1;
	wire pg_ch2 = i_page == PAGE_CH2;
	wire pg_both = i_page == PAGE_BOTH;
	wire off_ok = in_range(wr_mant, OFF_MANT_MIN, OFF_MANT_MAX);
	wire gain_ok = in_range(wr_mant, GAIN_MANT_MIN, GAIN_MANT_MAX);

	// a slave page 1 or an undefined page is refused outright
	wire gain_page_refused = is_gain & ~(pg_ch1 | pg_both | (pg_ch2 & ~i_ch2_slave));
	wire wr_refused = i_wr & (~known | gain_page_refused);
	wire rd_refused = i_rd & (~known | (is_gain & ~(pg_ch1 | pg_ch2 | pg_both)));
	wire wr_off = i_wr & is_off;
	wire wr_gain = i_wr & is_gain & ~gain_page_refused;
	wire bad_data = (wr_off & ~off_ok) | (wr_gain & ~gain_ok);
	wire wr_ch1 = wr_gain & gain_ok & (pg_ch1 | pg_both);
	// with a slave channel 2 the both-page write reaches channel 1 only
	wire wr_ch2 = wr_gain & gain_ok & (pg_ch2 | pg_both) & ~i_ch2_slave;

	wire [WORD_W-1:0] off_word = lin_word(OFF_EXP, off_mant);
	wire [WORD_W-1:0] g1_word = lin_word(GAIN_EXP, gain1_mant);
	wire [WORD_W-1:0] g2_word = lin_word(GAIN_EXP, i_ch2_slave ? gain1_mant : gain2_mant);
	wire [WORD_W-1:0] rd_word = is_off ? off_word : (pg_ch2 ? g2_word : g1_word);

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			off_mant <= P_OFF_MANT_POWERUP;
		end else if (wr_off & off_ok) begin
			off_mant <= wr_mant;
		end
	end

	// power-up value stands in for the stored user setting
	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			gain1_mant <= P_GAIN_MANT_POWERUP;
			gain2_mant <= P_GAIN_MANT_POWERUP;
		end else begin
			if (wr_ch1) begin
				gain1_mant <= wr_mant;
			end
			if (wr_ch2) begin
				gain2_mant <= wr_mant;
			end
		end
	end

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_ack <= 1'b0;
			o_nack <= 1'b0;
			o_rdata <= '0;
		end else begin
			o_ack <= (i_wr & ~wr_refused) | (i_rd & ~rd_refused);
			o_nack <= wr_refused | rd_refused;
			if (i_rd & ~rd_refused) begin
				o_rdata <= rd_word;
			end
		end
	end

	assign o_input_turn_off_threshold = off_word;
	assign o_gain_ch1 = g1_word;
	assign o_gain_ch2 = g2_word;

	pvg_sticky u_cml (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_set(bad_data | wr_refused | rd_refused),
		.i_clear(i_clear_faults),
		.o_flag(o_cml_fault)
	);

	pvg_sticky u_ivd (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_set(bad_data),
		.i_clear(i_clear_faults),
		.o_flag(o_invalid_data)
	);

	pvg_sticky u_ivc (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_set(wr_refused | rd_refused),
		.i_clear(i_clear_faults),
		.o_flag(o_invalid_command_fault)
	);

	// open-drain alert: only ever pulls low
	assign o_smbalert_out = 1'b0;
	assign o_smbalert_oe = o_cml_fault | o_invalid_data | o_invalid_command_fault;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	chk_off_exp_fixed: assert property (o_input_turn_off_threshold[WORD_W-1:EXP_LSB] == OFF_EXP)
		else $error("turn-off exponent changed");
	chk_gain_exp_fixed: assert property (o_gain_ch1[WORD_W-1:EXP_LSB] == GAIN_EXP
			&& o_gain_ch2[WORD_W-1:EXP_LSB] == GAIN_EXP)
		else $error("gain exponent changed");
	chk_off_bad_kept: assert property (wr_off && !off_ok |=>
			$stable(o_input_turn_off_threshold) && o_invalid_data && o_cml_fault && o_smbalert_oe)
		else $error("bad threshold write not handled");
	chk_off_good_taken: assert property (wr_off && off_ok |=>
			o_input_turn_off_threshold[MANT_W-1:0] == $past(i_wdata[MANT_W-1:0]))
		else $error("valid threshold write lost");
	chk_slave_page_nack: assert property (i_wr && is_gain && pg_ch2 && i_ch2_slave |=>
			o_nack && !o_ack && o_invalid_command_fault && o_smbalert_oe && $stable(o_gain_ch1))
		else $error("slave page write not refused");
	chk_slave_follows: assert property (i_ch2_slave |-> o_gain_ch2 == o_gain_ch1)
		else $error("slave channel 2 not following page 0");
	chk_page0_write: assert property (i_wr && is_gain && pg_ch1 && gain_ok |=>
			o_ack ##0 o_gain_ch1[MANT_W-1:0] == $past(i_wdata[MANT_W-1:0]))
		else $error("page 0 gain write lost");
	chk_gain_range: assert property (in_range(gain1_mant, GAIN_MANT_MIN, GAIN_MANT_MAX)
			&& in_range(gain2_mant, GAIN_MANT_MIN, GAIN_MANT_MAX))
		else $error("gain mantissa out of range");
	chk_page1_master: assert property (i_wr && is_gain && pg_ch2 && !i_ch2_slave && gain_ok |=>
			o_gain_ch2[MANT_W-1:0] == $past(i_wdata[MANT_W-1:0]) && $stable(o_gain_ch1))
		else $error("page 1 master write misrouted");

	// one answer per request, ack or nack but never both, never unasked
	chk_answer_once: assert property ((i_wr || i_rd) |=> (o_ack != o_nack))
		else $error("request not answered exactly once");
	chk_no_stray: assert property (!i_wr && !i_rd |=> !o_ack && !o_nack)
		else $error("answer without a request");

	// undefined commands, and gain commands on the undefined page, are refused outright
	chk_unknown_nack: assert property ((i_wr || i_rd) && !known |=>
			o_nack && o_invalid_command_fault && o_cml_fault)
		else $error("unknown command not refused");
	chk_page_undef: assert property ((i_wr || i_rd) && is_gain
			&& !(pg_ch1 || pg_ch2 || pg_both) |=> o_nack && o_invalid_command_fault)
		else $error("undefined page not refused");

	chk_gain_bad_kept: assert property (wr_gain && !gain_ok |=>
			$stable(o_gain_ch1) && o_ack && o_invalid_data && o_cml_fault)
		else $error("bad gain write not handled");
	chk_both_pages: assert property (wr_gain && gain_ok && pg_both && !i_ch2_slave |=>
			o_gain_ch2 == o_gain_ch1 && o_gain_ch1[MANT_W-1:0] == $past(i_wdata[MANT_W-1:0]))
		else $error("both-page write missed a channel");

	// read data is the word that stood when the read was taken
	chk_read_off: assert property (i_rd && is_off |=>
			o_ack && o_rdata == $past(o_input_turn_off_threshold))
		else $error("threshold read returned wrong word");
	chk_read_gain: assert property (i_rd && is_gain && pg_ch2 |=>
			o_ack && o_rdata == $past(o_gain_ch2))
		else $error("channel 2 gain read returned wrong word");

	// a clear with no new event in the same cycle empties every flag
	chk_flags_clear: assert property (i_clear_faults
			&& !(bad_data || wr_refused || rd_refused) |=> !o_smbalert_oe)
		else $error("fault flags not cleared");
endmodule : pvg_regs

// ---- pvg_pkg.sv ----
// command codes, field layout and power-up values of the threshold and gain commands
package pvg_pkg;
	localparam int unsigned CMD_W = 8;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned MANT_W = 11;
	localparam int unsigned EXP_W = 5;
	localparam int unsigned EXP_LSB = 11;
	localparam int unsigned PAGE_W = 2;

	localparam logic [CMD_W-1:0] CMD_INPUT_TURN_OFF = 8'h36;
	localparam logic [CMD_W-1:0] CMD_CURRENT_SENSE_GAIN = 8'h38;

	localparam logic [PAGE_W-1:0] PAGE_CH1 = 2'h0;
	localparam logic [PAGE_W-1:0] PAGE_CH2 = 2'h1;
	localparam logic [PAGE_W-1:0] PAGE_BOTH = 2'h3;

	// 11110 = -2, 0.25 V step
	localparam logic [EXP_W-1:0] OFF_EXP = 5'h1E;
	localparam logic [MANT_W-1:0] OFF_MANT_MIN = 11'h010;
	localparam logic [MANT_W-1:0] OFF_MANT_MAX = 11'h03F;
	localparam logic [MANT_W-1:0] OFF_MANT_DEF = 11'h018;

	// 10000 = -16, 15.26 micro-ohm step
	localparam logic [EXP_W-1:0] GAIN_EXP = 5'h10;
	localparam logic [MANT_W-1:0] GAIN_MANT_MIN = 11'h010;
	localparam logic [MANT_W-1:0] GAIN_MANT_MAX = 11'h1FC;
	localparam logic [MANT_W-1:0] GAIN_MANT_DEF = 11'h021;
endpackage : pvg_pkg

// ---- pvg_sticky.sv ----
// sticky status flag, a set in the clearing cycle wins
`timescale 1ns/1ps
module pvg_sticky (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_set,
	input wire logic i_clear,
	output logic o_flag
);
	logic next_flag;

	assign next_flag = i_set | (o_flag & ~i_clear);

	always_ff @(posedge i_clk or posedge i_reset) begin
		if (i_reset) begin
			o_flag <= 1'b0;
		end else begin
			o_flag <= next_flag;
		end
	end
endmodule : pvg_sticky

// ---- pvg_host.sv ----
// host model issuing one command word per request
`timescale 1ns/1ps
module pvg_host (
	input wire logic i_clk,
	output logic o_wr,
	output logic o_rd,
	output logic [pvg_pkg::CMD_W-1:0] o_cmd,
	output logic [pvg_pkg::PAGE_W-1:0] o_page,
	output logic [pvg_pkg::WORD_W-1:0] o_wdata
);
	initial begin
		{o_wr, o_rd, o_cmd, o_page, o_wdata} = '0;
	end
	// request held across exactly one rising edge
	task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [1:0] page,
		input logic [15:0] wd);
		@(negedge i_clk);
		{o_wr, o_rd, o_cmd, o_page, o_wdata} = {wr, ~wr, cmd, page, wd};
		@(negedge i_clk);
		{o_wr, o_rd} = 2'h0;
		// stale data inverted so nothing leans on it
		o_wdata = ~wd;
	endtask : xfer
endmodule : pvg_host

// ---- testbench.sv ----
// self-checking bench for the threshold and gain command registers
`timescale 1ns/1ps
module testbench;
	import pvg_pkg::*;
	logic i_clk, i_reset, i_wr, i_rd, i_ch2_slave, i_clear_faults, o_ack, o_nack;
	logic o_cml_fault, o_invalid_data, o_invalid_command_fault, o_smbalert_out, o_smbalert_oe;
	logic [7:0] i_cmd;
	logic [1:0] i_page;
	logic [15:0] i_wdata, o_rdata, o_input_turn_off_threshold, o_gain_ch1, o_gain_ch2;
	logic [15:0] e1, e2;
	logic [10:0] mant;
	logic [17:0] got;
	logic [17:0] exp_q[$];
	logic [1:0] pages[3] = '{PAGE_CH1, PAGE_CH2, PAGE_BOTH};
	int error_cnt = 0;
	int n_checks = 0;
	pvg_regs u_dut (.i_clk, .i_reset, .i_wr, .i_rd, .i_cmd, .i_page, .i_wdata, .i_ch2_slave,
		.i_clear_faults, .o_ack, .o_nack, .o_rdata, .o_input_turn_off_threshold, .o_gain_ch1,
		.o_gain_ch2, .o_cml_fault, .o_invalid_data, .o_invalid_command_fault, .o_smbalert_out,
		.o_smbalert_oe);
	pvg_host u_host (.i_clk, .o_wr(i_wr), .o_rd(i_rd), .o_cmd(i_cmd), .o_page(i_page),
		.o_wdata(i_wdata));
	task automatic cmp(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask : cmp
	task automatic req(input logic wr, input logic [7:0] c, input logic [1:0] p,
		input logic [15:0] wd, input logic nk, input logic [15:0] rd);
		exp_q.push_back({~wr, nk, rd});
		u_host.xfer(wr, c, p, wd);
		@(negedge i_clk);
	endtask : req
	task automatic flags(input logic [4:0] e);
		cmp({o_smbalert_out, o_invalid_data, o_cml_fault, o_invalid_command_fault,
			o_smbalert_oe}, e);
		@(negedge i_clk) i_clear_faults = 1'b1;
		@(negedge i_clk) i_clear_faults = 1'b0;
	endtask : flags
	task automatic report_and_stop;
		if (exp_q.size() != 0) begin
			error_cnt++;
			$display("Error at %0t: pending answers %h expected %h", $time, exp_q.size(), 0);
		end
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	// watcher takes the oldest note off the queue at each answer
	always @(posedge i_clk) begin
		#1;
		if (o_ack === 1'b1 || o_nack === 1'b1) begin
			got = (exp_q.size() > 0) ? exp_q.pop_front() : 18'h3FFFF;
			cmp(o_nack, got[16]);
			cmp(o_ack, !got[16]);
			if (got[17] && o_nack === 1'b0) cmp(o_rdata, got[15:0]);
		end
	end
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	initial begin
		#50000;
		error_cnt++;
		report_and_stop();
	end
	initial begin
		{i_reset, i_ch2_slave, i_clear_faults} = 3'h4;
		void'($urandom(48));
		repeat (5) @(posedge i_clk);
		@(negedge i_clk) i_reset = 1'b0;
		cmp(o_input_turn_off_threshold, 16'hF018);
		cmp(o_gain_ch1, 16'h8021);
		cmp(o_gain_ch2, 16'h8021);
		req(1, CMD_INPUT_TURN_OFF, 2'h0, 16'h0810, 0, 0);
		req(0, CMD_INPUT_TURN_OFF, 2'h0, 0, 0, 16'hF010);
		// stays below the 6.25 V turn-on default, which this block cannot see
		req(1, CMD_INPUT_TURN_OFF, 2'h0, 16'hF817, 0, 0);
		req(1, CMD_INPUT_TURN_OFF, 2'h0, 16'h0040, 0, 0);
		cmp(o_input_turn_off_threshold, 16'hF017);
		flags(5'h0D);
		$display("threshold test done");
		{e1, e2} = {16'h8021, 16'h8021};
		for (int k = 0; k < 6; k++) begin
			mant = (k < 3) ? 11'(16 + $urandom % 493) : (k == 3 ? 11'd16 : 11'd508);
			if (pages[k % 3] != PAGE_CH2) e1 = {GAIN_EXP, mant};
			if (pages[k % 3] != PAGE_CH1) e2 = {GAIN_EXP, mant};
			req(1, CMD_CURRENT_SENSE_GAIN, pages[k % 3], {5'h1F, mant}, 0, 0);
			cmp(o_gain_ch1, e1);
			cmp(o_gain_ch2, e2);
		end
		// 0.5 milliohm is the nearest step, 33 of 15.26 microohm
		{e1, e2} = {16'h8021, 16'h8021};
		req(1, CMD_CURRENT_SENSE_GAIN, PAGE_BOTH, 16'h0021, 0, 0);
		cmp(o_gain_ch1, e1);
		cmp(o_gain_ch2, e2);
		req(1, CMD_CURRENT_SENSE_GAIN, PAGE_CH1, 16'h01FD, 0, 0);
		cmp(o_gain_ch1, e1);
		flags(5'h0D);
		$display("gain page test done");
		i_ch2_slave = 1'b1;
		req(1, CMD_CURRENT_SENSE_GAIN, PAGE_CH2, 16'h0040, 1, 0);
		flags(5'h07);
		req(1, CMD_CURRENT_SENSE_GAIN, PAGE_CH1, 16'h0055, 0, 0);
		cmp(o_gain_ch2, 16'h8055);
		req(0, CMD_CURRENT_SENSE_GAIN, PAGE_CH2, 0, 0, 16'h8055);
		req(1, CMD_CURRENT_SENSE_GAIN, PAGE_BOTH, 16'h0077, 0, 0);
		cmp(o_gain_ch2, 16'h8077);
		i_ch2_slave = 1'b0;
		@(negedge i_clk) cmp(o_gain_ch2, e2);
		$display("slave test done");
		req(1, 8'h00, PAGE_CH1, 16'h0018, 1, 0);
		req(0, CMD_CURRENT_SENSE_GAIN, 2'h2, 0, 1, 0);
		flags(5'h07);
		$display("refusal test done");
		@(negedge i_clk) i_reset = 1'b1;
		@(negedge i_clk) i_reset = 1'b0;
		cmp(o_input_turn_off_threshold, 16'hF018);
		cmp(o_gain_ch1, 16'h8021);
		req(0, CMD_INPUT_TURN_OFF, 2'h0, 0, 0, 16'hF018);
		$display("reset test done");
		report_and_stop();
	end
endmodule : testbench
